//--- fip_core_model.sv
/*
  Behavioural processor core: takes a shown request after a delay.
  Assumes the controller request is a registered level.
*/
`timescale 1ns/100ps

module fip_core_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // controller side
  input wire logic irq_req_i,
  output logic core_ack_o,
  // bench control
  input wire logic en_i,
  input wire logic [3:0] dly_i
);
  logic [3:0] wait_r;

  // ==========================================================
  // acknowledge only while a request is shown
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !en_i || !irq_req_i || core_ack_o) begin
      wait_r <= 4'h0;
      core_ack_o <= 1'b0;
    end else if (wait_r == dly_i) begin
      core_ack_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

//--- fip_ctrl.sv
/*
  Four-level interrupt priority controller: enables, priority bits,
  request flags, arbitration with nesting and fixed vectors.
  Assumes an 8-bit special-function bus on the core clock, a core that
  acknowledges only while a request is shown and signals handler return,
  and sources on the same clock except the two external pins.
*/
`timescale 1ns/100ps
`include "fip_map.svh"

module fip_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // special-function bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // external request pins, active low
  input wire logic external_source_zero_n_i,
  input wire logic external_source_one_n_i,
  input wire logic ext0_edge_mode_i,
  input wire logic ext1_edge_mode_i,
  // on-chip sources
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic receive_done_flag_i,
  input wire logic transmit_done_flag_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic timer2_external_flag_i,
  // request flags held here
  output logic ext0_request_flag_o,
  output logic timer0_overflow_flag_o,
  output logic ext1_request_flag_o,
  output logic timer1_overflow_flag_o,
  // processor core
  output logic irq_req_o,
  output logic [7:0] irq_vector_o,
  output logic [1:0] irq_level_o,
  input wire logic core_ack_i,
  input wire logic core_reti_i
);

  fip_svc_if svc();

  logic [7:0] enable_r;
  logic [5:0] prio_upper_r;
  logic [5:0] prio_lower_r;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [1:0] ext0_sync_r;
  logic [1:0] ext1_sync_r;
  logic ext0_prev_r;
  logic ext1_prev_r;
  logic ext0_fall;
  logic ext1_fall;
  logic [5:0] request;
  logic [5:0] pending;
  logic best_found;
  fip_pkg::fip_level_t best_level;
  fip_pkg::fip_src_t best_src;
  logic eligible;
  logic [7:0] best_vector;
  logic irq_req_r;
  logic [7:0] irq_vector_r;
  fip_pkg::fip_level_t irq_level_r;
  fip_pkg::fip_src_t taken_src_r;
  logic [7:0] rdata_r;
  logic hit_r;
  logic wr_enable;
  logic wr_upper;
  logic wr_lower;
  logic wr_flags;
  logic take;

  // ==========================================================
  // in-service tracker
  fip_svc_stack u_svc_stack (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .svc(svc.stack)
  );

  // ==========================================================
  // register writes
  assign wr_enable = sfr_wr_i && (sfr_addr_i == `FIP_ADDR_ENABLE);
  assign wr_upper = sfr_wr_i && (sfr_addr_i == `FIP_ADDR_PRIO_UPPER);
  assign wr_lower = sfr_wr_i && (sfr_addr_i == `FIP_ADDR_PRIO_LOWER);
  assign wr_flags = sfr_wr_i && (sfr_addr_i == `FIP_ADDR_FLAGS);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      enable_r <= `FIP_RST_ENABLE;
    end else if (wr_enable) begin
      enable_r <= sfr_wdata_i & `FIP_EN_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prio_upper_r <= `FIP_RST_PRIO;
      prio_lower_r <= `FIP_RST_PRIO;
    end else begin
      if (wr_upper) begin
        prio_upper_r <= sfr_wdata_i[5:0];
      end
      if (wr_lower) begin
        prio_lower_r <= sfr_wdata_i[5:0];
      end
    end
  end

  // ==========================================================
  // register reads, registered one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end else begin
      hit_r <= 1'b0;
      if (sfr_rd_i) begin
        hit_r <= 1'b1;
        unique case (sfr_addr_i)
          `FIP_ADDR_ENABLE: rdata_r <= enable_r;
          `FIP_ADDR_PRIO_UPPER: rdata_r <= {2'h0, prio_upper_r};
          `FIP_ADDR_PRIO_LOWER: rdata_r <= {2'h0, prio_lower_r};
          `FIP_ADDR_FLAGS: rdata_r <= {4'h0, flags_r};
          default: begin
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // external pin synchronisers and fall detect
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ext0_sync_r <= 2'h3;
      ext1_sync_r <= 2'h3;
      ext0_prev_r <= 1'b1;
      ext1_prev_r <= 1'b1;
    end else begin
      ext0_sync_r <= {ext0_sync_r[0], external_source_zero_n_i};
      ext1_sync_r <= {ext1_sync_r[0], external_source_one_n_i};
      ext0_prev_r <= ext0_sync_r[1];
      ext1_prev_r <= ext1_sync_r[1];
    end
  end

  assign ext0_fall = ext0_prev_r && !ext0_sync_r[1];
  assign ext1_fall = ext1_prev_r && !ext1_sync_r[1];

  // ==========================================================
  // request flags; a set in the clearing cycle wins
  assign take = core_ack_i && irq_req_r;

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = flags_r & sfr_wdata_i[3:0];
    end
    if (take) begin
      unique case (taken_src_r)
        fip_pkg::FIP_SRC_EXT0: begin
          flags_nxt[`FIP_FLG_EXT0_BIT] = 1'b0;
        end
        fip_pkg::FIP_SRC_TMR0: begin
          flags_nxt[`FIP_FLG_TMR0_BIT] = 1'b0;
        end
        fip_pkg::FIP_SRC_EXT1: begin
          flags_nxt[`FIP_FLG_EXT1_BIT] = 1'b0;
        end
        fip_pkg::FIP_SRC_TMR1: begin
          flags_nxt[`FIP_FLG_TMR1_BIT] = 1'b0;
        end
        fip_pkg::FIP_SRC_SER, fip_pkg::FIP_SRC_TMR2: begin
          flags_nxt = flags_nxt;
        end
        default: begin
          flags_nxt = flags_nxt;
        end
      endcase
    end
    // transition mode latches a fall; level mode follows the pin
    if (ext0_edge_mode_i) begin
      if (ext0_fall) begin
        flags_nxt[`FIP_FLG_EXT0_BIT] = 1'b1;
      end
    end else begin
      flags_nxt[`FIP_FLG_EXT0_BIT] = !ext0_sync_r[1];
    end
    if (ext1_edge_mode_i) begin
      if (ext1_fall) begin
        flags_nxt[`FIP_FLG_EXT1_BIT] = 1'b1;
      end
    end else begin
      flags_nxt[`FIP_FLG_EXT1_BIT] = !ext1_sync_r[1];
    end
    if (timer0_overflow_i) begin
      flags_nxt[`FIP_FLG_TMR0_BIT] = 1'b1;
    end
    if (timer1_overflow_i) begin
      flags_nxt[`FIP_FLG_TMR1_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flags_r <= `FIP_RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // arbitration over six sources in polling order
  assign request = {
    timer2_overflow_flag_i | timer2_external_flag_i,
    receive_done_flag_i | transmit_done_flag_i,
    flags_r[`FIP_FLG_TMR1_BIT],
    flags_r[`FIP_FLG_EXT1_BIT],
    flags_r[`FIP_FLG_TMR0_BIT],
    flags_r[`FIP_FLG_EXT0_BIT]
  };

  assign pending = request & enable_r[`FIP_EN_SRC_MSB:0] &
    {`FIP_NUM_SRC{enable_r[`FIP_EN_GATE_BIT]}};

  always_comb begin
    best_found = 1'b0;
    best_level = 2'h0;
    best_src = fip_pkg::FIP_SRC_EXT0;
    for (int i = 0; i < `FIP_NUM_SRC; i++) begin
      // strict compare keeps the earlier source on a tie
      if (pending[i] && (!best_found ||
          {prio_upper_r[i], prio_lower_r[i]} > best_level)) begin
        best_found = 1'b1;
        best_level = {prio_upper_r[i], prio_lower_r[i]};
        best_src = fip_pkg::fip_src_t'(3'(i));
      end
    end
  end

  assign eligible = best_found &&
    (!svc.active || (best_level > svc.top_level));

  always_comb begin
    unique case (best_src)
      fip_pkg::FIP_SRC_EXT0: best_vector = `FIP_VEC_EXT0;
      fip_pkg::FIP_SRC_TMR0: best_vector = `FIP_VEC_TMR0;
      fip_pkg::FIP_SRC_EXT1: best_vector = `FIP_VEC_EXT1;
      fip_pkg::FIP_SRC_TMR1: best_vector = `FIP_VEC_TMR1;
      fip_pkg::FIP_SRC_SER: best_vector = `FIP_VEC_SER;
      fip_pkg::FIP_SRC_TMR2: best_vector = `FIP_VEC_TMR2;
      default: best_vector = `FIP_VEC_EXT0;
    endcase
  end

  // ==========================================================
  // request to the core, dropped the cycle after the acknowledge
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_req_r <= 1'b0;
      irq_vector_r <= 8'h00;
      irq_level_r <= 2'h0;
      taken_src_r <= fip_pkg::FIP_SRC_EXT0;
    end else begin
      irq_req_r <= eligible && !take;
      irq_vector_r <= best_vector;
      irq_level_r <= best_level;
      taken_src_r <= best_src;
    end
  end

  // ==========================================================
  // nesting bookkeeping
  assign svc.push = take;
  assign svc.push_level = irq_level_r;
  assign svc.pop = core_reti_i;

  // ==========================================================
  // outputs
  assign sfr_rdata_o = rdata_r;
  assign sfr_hit_o = hit_r;
  assign ext0_request_flag_o = flags_r[`FIP_FLG_EXT0_BIT];
  assign timer0_overflow_flag_o = flags_r[`FIP_FLG_TMR0_BIT];
  assign ext1_request_flag_o = flags_r[`FIP_FLG_EXT1_BIT];
  assign timer1_overflow_flag_o = flags_r[`FIP_FLG_TMR1_BIT];
  assign irq_req_o = irq_req_r;
  assign irq_vector_o = irq_vector_r;
  assign irq_level_o = irq_level_r;

endmodule

//--- fip_ctrl_sva.sv
/*
  Port checker of the interrupt priority controller.
  Assumes it is bound to fip_ctrl, one clock, synchronous reset.
*/
`timescale 1ns/100ps
`include "fip_map.svh"

module fip_ctrl_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  // sources and flags
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic ext0_edge_mode_i,
  input wire logic ext0_request_flag_o,
  input wire logic timer0_overflow_flag_o,
  input wire logic timer1_overflow_flag_o,
  // core side
  input wire logic irq_req_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic [1:0] irq_level_o,
  input wire logic core_ack_i,
  input wire logic core_reti_i
);
  logic [7:0] en_r;
  logic [5:0] up_r, lo_r, up_q, lo_q;
  logic [3:0] busy_r, busy_q, busy_nxt;
  logic take;

  function automatic logic [1:0] top(input logic [3:0] b);
    top = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) top = i[1:0];
    end
  endfunction

  assign take = core_ack_i && irq_req_o;

  // ==========================================================
  // register mirrors and in-service levels
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      en_r <= 8'h00;
      up_r <= 6'h00;
      lo_r <= 6'h00;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == `FIP_ADDR_ENABLE) en_r <= sfr_wdata_i & `FIP_EN_WMASK;
      if (sfr_addr_i == `FIP_ADDR_PRIO_UPPER) up_r <= sfr_wdata_i[5:0];
      if (sfr_addr_i == `FIP_ADDR_PRIO_LOWER) lo_r <= sfr_wdata_i[5:0];
    end
  end

  always_comb begin
    busy_nxt = busy_r;
    if (core_reti_i) busy_nxt = busy_r & ~(4'h1 << top(busy_r));
    if (take) busy_nxt = busy_nxt | (4'h1 << irq_level_o);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      busy_r <= 4'h0;
      busy_q <= 4'h0;
      up_q <= 6'h00;
      lo_q <= 6'h00;
    end else begin
      busy_r <= busy_nxt;
      busy_q <= busy_r;
      up_q <= up_r;
      lo_q <= lo_r;
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  ack_drops_req_a: assert property (take |=> !irq_req_o)
    else $error("request still shown after acknowledge");
  vec_fixed_a: assert property (irq_req_o |-> irq_vector_o inside {
    `FIP_VEC_EXT0, `FIP_VEC_TMR0, `FIP_VEC_EXT1, `FIP_VEC_TMR1,
    `FIP_VEC_SER, `FIP_VEC_TMR2})
    else $error("vector outside table");
  level_join_a: assert property ($rose(irq_req_o) |-> irq_level_o ==
    {up_q[irq_vector_o[5:3]], lo_q[irq_vector_o[5:3]]})
    else $error("level differs from priority bits");
  preempt_only_a: assert property ($rose(irq_req_o) && busy_q != 4'h0
    |-> irq_level_o > top(busy_q))
    else $error("request not above level in service");
  gate_off_a: assert property ((!en_r[7]) [*2] |-> !irq_req_o)
    else $error("request while gate closed");
  tmr0_clear_a: assert property (take && irq_vector_o == `FIP_VEC_TMR0
    && !timer0_overflow_i |=> !timer0_overflow_flag_o)
    else $error("timer0 flag not cleared on vectoring");
  ext0_clear_a: assert property (take && irq_vector_o == `FIP_VEC_EXT0
    && ext0_edge_mode_i |=> !ext0_request_flag_o)
    else $error("ext0 edge flag not cleared on vectoring");
  tmr1_set_a: assert property (timer1_overflow_i && !take
    |=> timer1_overflow_flag_o)
    else $error("timer1 flag not set");
  read_hit_a: assert property (sfr_rd_i |=> sfr_hit_o ==
    ($past(sfr_addr_i) inside {`FIP_ADDR_ENABLE, `FIP_ADDR_PRIO_UPPER,
    `FIP_ADDR_PRIO_LOWER, `FIP_ADDR_FLAGS}))
    else $error("read hit wrong");
  enable_read_a: assert property (sfr_rd_i && !sfr_wr_i &&
    sfr_addr_i == `FIP_ADDR_ENABLE |=> sfr_rdata_o == en_r)
    else $error("enable readback wrong");
endmodule

bind fip_ctrl fip_ctrl_sva chk_u (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o),
  .timer0_overflow_i(timer0_overflow_i),
  .timer1_overflow_i(timer1_overflow_i),
  .ext0_edge_mode_i(ext0_edge_mode_i),
  .ext0_request_flag_o(ext0_request_flag_o),
  .timer0_overflow_flag_o(timer0_overflow_flag_o),
  .timer1_overflow_flag_o(timer1_overflow_flag_o),
  .irq_req_o(irq_req_o),
  .irq_vector_o(irq_vector_o),
  .irq_level_o(irq_level_o),
  .core_ack_i(core_ack_i),
  .core_reti_i(core_reti_i)
);

//--- fip_map.svh
/*
  Address map, field positions, reset values and vector addresses of the
  four-level interrupt priority controller.
  Assumes the special-function bus carries 8-bit addresses and data.
*/
`ifndef FIP_MAP_SVH
`define FIP_MAP_SVH

// ==========================================================
// special-function addresses
`define FIP_ADDR_ENABLE 8'ha8
`define FIP_ADDR_PRIO_UPPER 8'hb7
`define FIP_ADDR_PRIO_LOWER 8'hb8
`define FIP_ADDR_FLAGS 8'h88

// ==========================================================
// reset values
`define FIP_RST_ENABLE 8'h00
`define FIP_RST_PRIO 6'h00
`define FIP_RST_FLAGS 4'h0

// ==========================================================
// enable register fields
`define FIP_EN_GATE_BIT 7
`define FIP_EN_SRC_MSB 5
`define FIP_EN_WMASK 8'hbf

// ==========================================================
// request flag register fields
`define FIP_FLG_EXT0_BIT 0
`define FIP_FLG_TMR0_BIT 1
`define FIP_FLG_EXT1_BIT 2
`define FIP_FLG_TMR1_BIT 3

// ==========================================================
// source count and vectors
`define FIP_NUM_SRC 6
`define FIP_VEC_EXT0 8'h03
`define FIP_VEC_TMR0 8'h0b
`define FIP_VEC_EXT1 8'h13
`define FIP_VEC_TMR1 8'h1b
`define FIP_VEC_SER 8'h23
`define FIP_VEC_TMR2 8'h2b

`endif

//--- fip_pkg.sv
/*
  Types of the four-level interrupt priority controller.
  Assumes fip_map.svh is available for the numeric constants.
*/
package fip_pkg;

  // two-bit priority level, 3 is highest
  typedef logic [1:0] fip_level_t;

  // source index in polling order
  typedef enum logic [2:0] {
    FIP_SRC_EXT0 = 3'h0,
    FIP_SRC_TMR0 = 3'h1,
    FIP_SRC_EXT1 = 3'h2,
    FIP_SRC_TMR1 = 3'h3,
    FIP_SRC_SER = 3'h4,
    FIP_SRC_TMR2 = 3'h5
  } fip_src_t;

endpackage

//--- fip_svc_if.sv
/*
  Carrier between the controller and its in-service level tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface fip_svc_if;
  logic push;
  fip_pkg::fip_level_t push_level;
  logic pop;
  logic active;
  fip_pkg::fip_level_t top_level;

  modport ctrl (
    output push,
    output push_level,
    output pop,
    input active,
    input top_level
  );

  modport stack (
    input push,
    input push_level,
    input pop,
    output active,
    output top_level
  );
endinterface

//--- fip_svc_stack.sv
/*
  In-service level tracker: one busy bit per priority level.
  Assumes push only for a level above the current top, pop on handler end.
*/
`timescale 1ns/100ps

module fip_svc_stack (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // controller side
  fip_svc_if.stack svc
);

  logic [3:0] busy_r;
  logic [3:0] busy_nxt;
  logic [3:0] pop_mask;

  // ==========================================================
  // top level in service
  always_comb begin
    svc.active = |busy_r;
    svc.top_level = 2'h0;
    pop_mask = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (busy_r[i]) begin
        svc.top_level = 2'(i);
        pop_mask = 4'h0;
        pop_mask[i] = 1'b1;
      end
    end
  end

  // ==========================================================
  // pop ends the preempting handler, resuming the one below
  always_comb begin
    busy_nxt = busy_r;
    if (svc.pop) begin
      busy_nxt = busy_nxt & ~pop_mask;
    end
    if (svc.push) begin
      busy_nxt[svc.push_level] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      busy_r <= 4'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

endmodule

//--- tb_four_level_interrupt_priority.sv
/*
  Self-checking bench of the interrupt priority controller.
  Assumes fip_ctrl, its checker and fip_core_model compiled first.
*/
`timescale 1ns/100ps
`include "fip_map.svh"

module tb_four_level_interrupt_priority;
  logic clk, rst, wr, rd, hit, req, mack, tack, reti, men;
  logic x0n, x1n, m0, m1, tm0, tm1, rx, tx, tm2, ex2;
  logic [7:0] addr, wd, rdata, vec;
  logic [1:0] lvl;
  logic [3:0] fl, dly;
  int miscompares, tests_run, cyc;
  logic [7:0] vt [6] = '{`FIP_VEC_EXT0, `FIP_VEC_TMR0, `FIP_VEC_EXT1,
    `FIP_VEC_TMR1, `FIP_VEC_SER, `FIP_VEC_TMR2};
  int ord [6] = '{5, 4, 1, 3, 0, 2};
  logic [1:0] lv [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};

  fip_ctrl dut_u (
    .sys_clk_i(clk), .sys_rst_i(rst),
    .sfr_addr_i(addr), .sfr_wdata_i(wd), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .external_source_zero_n_i(x0n), .external_source_one_n_i(x1n),
    .ext0_edge_mode_i(m0), .ext1_edge_mode_i(m1),
    .timer0_overflow_i(tm0), .timer1_overflow_i(tm1),
    .receive_done_flag_i(rx), .transmit_done_flag_i(tx),
    .timer2_overflow_flag_i(tm2), .timer2_external_flag_i(ex2),
    .ext0_request_flag_o(fl[0]), .timer0_overflow_flag_o(fl[1]),
    .ext1_request_flag_o(fl[2]), .timer1_overflow_flag_o(fl[3]),
    .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl),
    .core_ack_i(mack | tack), .core_reti_i(reti)
  );

  fip_core_model mdl_u (
    .sys_clk_i(clk), .sys_rst_i(rst), .irq_req_i(req),
    .core_ack_o(mack), .en_i(men), .dly_i(dly)
  );

  // ==========================================================
  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done;
    end
  end

  // ==========================================================
  // shared tasks
  task cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cy(1);
    wr = 1'b0;
    cy(1);
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] e, input logic h);
    addr = a;
    rd = 1'b1;
    cy(1);
    rd = 1'b0;
    chk(rdata, e);
    chk(hit, h);
    cy(1);
  endtask

  task waitq(input logic e);
    int n;
    n = 0;
    while (req !== e && n < 40) begin
      cy(1);
      n++;
    end
    chk(req, e);
  endtask

  task take(input logic [7:0] v, input logic [1:0] l);
    waitq(1'b1);
    chk(vec, v);
    chk(lvl, l);
    men = 1'b1;
    waitq(1'b0);
    men = 1'b0;
  endtask

  task ret;
    reti = 1'b1;
    cy(1);
    reti = 1'b0;
    cy(1);
  endtask

  task fire(input int i);
    case (i)
      0: x0n = 1'b0;
      1: tm0 = 1'b1;
      2: x1n = 1'b0;
      3: tm1 = 1'b1;
      4: rx = 1'b1;
      default: tm2 = 1'b1;
    endcase
    cy(1);
    {x0n, x1n, tm0, tm1} = 4'hc;
    cy(1);
  endtask

  // ==========================================================
  // scenarios
  task test_regs;
    rchk(`FIP_ADDR_ENABLE, 8'h00, 1'b1);
    rchk(`FIP_ADDR_PRIO_UPPER, 8'h00, 1'b1);
    rchk(`FIP_ADDR_PRIO_LOWER, 8'h00, 1'b1);
    wreg(`FIP_ADDR_ENABLE, 8'hff);
    rchk(`FIP_ADDR_ENABLE, 8'hbf, 1'b1);
    wreg(`FIP_ADDR_PRIO_UPPER, 8'hff);
    rchk(`FIP_ADDR_PRIO_UPPER, 8'h3f, 1'b1);
    wreg(`FIP_ADDR_PRIO_LOWER, 8'hc5);
    rchk(`FIP_ADDR_PRIO_LOWER, 8'h05, 1'b1);
    rchk(8'h55, 8'h00, 1'b0);
    wreg(`FIP_ADDR_ENABLE, 8'h00);
    wreg(`FIP_ADDR_PRIO_UPPER, 8'h00);
    wreg(`FIP_ADDR_PRIO_LOWER, 8'h00);
    $display("test_regs done");
  endtask

  task test_vec;
    for (int i = 0; i < 6; i++) begin
      wreg(`FIP_ADDR_ENABLE, 8'h80 | (8'h01 << i));
      fire(i);
      take(vt[i], 2'h0);
      chk(fl, 4'h0);
      ret();
      if (i > 3) begin
        waitq(1'b1);
        rx = 1'b0;
        tm2 = 1'b0;
        waitq(1'b0);
        {tx, ex2} = {i == 4, i == 5};
        waitq(1'b1);
        chk(vec, vt[i]);
        {tx, ex2} = 2'h0;
        waitq(1'b0);
      end
    end
    $display("test_vec done");
  endtask

  task test_prio;
    wreg(`FIP_ADDR_PRIO_UPPER, 8'h30);
    wreg(`FIP_ADDR_PRIO_LOWER, 8'h2a);
    wreg(`FIP_ADDR_ENABLE, 8'hbf);
    for (int i = 0; i < 6; i++) fire(i);
    for (int k = 0; k < 6; k++) begin
      take(vt[ord[k]], lv[k]);
      if (ord[k] == 4) rx = 1'b0;
      if (ord[k] == 5) tm2 = 1'b0;
      ret();
    end
    $display("test_prio done");
  endtask

  task test_nest;
    dly = 4'h3;
    wreg(`FIP_ADDR_PRIO_UPPER, 8'h10);
    wreg(`FIP_ADDR_PRIO_LOWER, 8'h0c);
    wreg(`FIP_ADDR_ENABLE, 8'h9c);
    fire(2);
    take(vt[2], 2'h1);
    fire(3);
    cy(5);
    chk(req, 1'b0);
    fire(4);
    take(vt[4], 2'h2);
    rx = 1'b0;
    ret();
    cy(5);
    chk(req, 1'b0);
    ret();
    take(vt[3], 2'h1);
    ret();
    dly = 4'h0;
    $display("test_nest done");
  endtask

  task test_gate;
    wreg(`FIP_ADDR_PRIO_UPPER, 8'h00);
    wreg(`FIP_ADDR_PRIO_LOWER, 8'h00);
    wreg(`FIP_ADDR_ENABLE, 8'h03);
    fire(1);
    cy(3);
    chk(req, 1'b0);
    tack = 1'b1;
    cy(1);
    tack = 1'b0;
    cy(1);
    chk(fl, 4'h2);
    rchk(`FIP_ADDR_FLAGS, 8'h02, 1'b1);
    wreg(`FIP_ADDR_FLAGS, 8'h00);
    chk(fl, 4'h0);
    fire(1);
    wreg(`FIP_ADDR_ENABLE, 8'h83);
    take(vt[1], 2'h0);
    ret();
    {m0, m1} = 2'h0;
    {x0n, x1n} = 2'h0;
    take(vt[0], 2'h0);
    chk(fl[0], 1'b1);
    chk(fl[2], 1'b1);
    {x0n, x1n} = 2'h3;
    cy(4);
    chk(fl, 4'h0);
    ret();
    $display("test_gate done");
  endtask

  task test_done;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rst, wr, rd, tack, reti, men, tm0, tm1, rx, tx, tm2, ex2} = 12'h800;
    {x0n, x1n, m0, m1} = 4'hf;
    {addr, wd, dly} = 20'h00000;
    cy(6);
    rst = 1'b0;
    test_regs;
    test_vec;
    test_prio;
    test_nest;
    test_gate;
    test_done;
  end
endmodule
